// ---- core/xirq_edge.sv ----
// Purpose: Pin synchroniser with single-event edge detection
// Assumes: Pin is asynchronous to mclk
// Notes: First level after reset only primes the detector, never fires; reset spans 3 clocks
`timescale 1ns/1ps
`default_nettype none
module xirq_edge
   import xirq_pkg::*;
#(
   parameter bit RISING = 1'b1
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Pin and detected event
   input wire logic pin,
   output logic edge_pulse
);

   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic level_q;
   logic level_d;
   logic primed_q;
   logic primed_d;
   logic agree;

   always_comb begin
      sync_d = {sync_q[1:0], pin};
      agree = (sync_q[1] == sync_q[2]);
      level_d = agree ? sync_q[2] : level_q;
      primed_d = primed_q | agree;
      edge_pulse = agree && primed_q && (sync_q[2] != level_q) && (sync_q[2] == RISING);
   end

   // Chain keeps sampling in reset; a cleared chain would fake an edge on a high pin
   always_ff @(posedge mclk) begin
      sync_q <= sync_d;
      if (srst) begin
         level_q <= 1'b0;
         primed_q <= 1'b0;
      end else begin
         level_q <= level_d;
         primed_q <= primed_d;
      end
   end

endmodule : xirq_edge
`default_nettype wire

// ---- core/xirq_pkg.sv ----
// Purpose: Shared constants and types for the extended interrupt source block
// Assumes: Byte-wide special-function registers on the core clock
// Notes: Source bit order follows the fixed natural order, lowest index first
package xirq_pkg;

   // Special-function register addresses
   localparam logic [7:0] XIRQ_OFS_FLAGS = 8'h91;
   localparam logic [7:0] XIRQ_OFS_WAKE = 8'hd8;
   localparam logic [7:0] XIRQ_OFS_EN = 8'he8;
   localparam logic [7:0] XIRQ_OFS_PRI = 8'hf8;

   // Flag register fields
   localparam int XIRQ_FLG_PIN5 = 7;
   localparam int XIRQ_FLG_PIN4 = 6;
   localparam int XIRQ_FLG_TW = 5;
   localparam int XIRQ_FLG_USB = 4;

   // Wake-control register fields
   localparam int XIRQ_WAKE_DBL = 7;
   localparam int XIRQ_WAKE_ERES = 5;
   localparam int XIRQ_WAKE_RESUME_FLAG = 4;
   localparam int XIRQ_WAKE_PIN6 = 3;

   // Enable and priority fields share one layout
   localparam int XIRQ_SRC_PIN6 = 4;
   localparam int XIRQ_SRC_PIN5 = 3;
   localparam int XIRQ_SRC_PIN4 = 2;
   localparam int XIRQ_SRC_TW = 1;
   localparam int XIRQ_SRC_USB = 0;
   localparam int XIRQ_NSRC = 5;

   // Bits that read as fixed ones, and the all-zero value of an unmapped read
   localparam logic [7:0] XIRQ_FLAGS_ONES = 8'h08;
   localparam logic [7:0] XIRQ_WAKE_ONES = 8'h40;
   localparam logic [7:0] XIRQ_EN_ONES = 8'he0;
   localparam logic [7:0] XIRQ_PRI_ONES = 8'he0;
   localparam logic [7:0] XIRQ_UNMAPPED = 8'h00;

   // Reset values of stored state
   localparam logic [4:0] XIRQ_RST_SRC = 5'h00;
   localparam logic XIRQ_RST_BIT = 1'b0;
   localparam logic [7:0] XIRQ_RST_BYTE = 8'h00;

   // Natural priority numbers handed to the sequencer
   localparam logic [3:0] XIRQ_NUM_RESUME = 4'h0;
   localparam logic [3:0] XIRQ_NUM_BASE = 4'h8;

   // Assigned levels
   localparam logic [1:0] XIRQ_LVL_LOW = 2'h0;
   localparam logic [1:0] XIRQ_LVL_HIGH = 2'h1;
   localparam logic [1:0] XIRQ_LVL_TOP = 2'h2;

   // One bit per source, packed so that usb sits at bit 0
   typedef struct packed {
      logic pin6;
      logic pin5;
      logic pin4;
      logic twowire;
      logic usb;
   } xirq_req_t;

endpackage : xirq_pkg

// ---- core/xirq_prio.sv ----
// Purpose: Picks the winning request by assigned level, then natural order
// Assumes: Requests already gated by their enables
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module xirq_prio
   import xirq_pkg::*;
(
   // Requests and assigned levels
   input wire logic resume_req,
   input wire logic [XIRQ_NSRC-1:0] req,
   input wire logic [XIRQ_NSRC-1:0] high,
   // Winner
   output logic valid,
   output logic [1:0] level,
   output logic [3:0] num
);

   logic [XIRQ_NSRC-1:0] hi_req;
   logic [XIRQ_NSRC-1:0] lo_req;

   always_comb begin
      hi_req = req & high;
      lo_req = req & ~high;
      valid = 1'b0;
      level = XIRQ_LVL_LOW;
      num = XIRQ_NUM_RESUME;
      // lowest index wins within a group
      for (int i = XIRQ_NSRC - 1; i >= 0; i--) begin
         if (lo_req[i]) begin
            valid = 1'b1;
            level = XIRQ_LVL_LOW;
            num = XIRQ_NUM_BASE + 4'(i);
         end
      end
      for (int i = XIRQ_NSRC - 1; i >= 0; i--) begin
         if (hi_req[i]) begin
            valid = 1'b1;
            level = XIRQ_LVL_HIGH;
            num = XIRQ_NUM_BASE + 4'(i);
         end
      end
      if (resume_req) begin
         valid = 1'b1;
         level = XIRQ_LVL_TOP;
         num = XIRQ_NUM_RESUME;
      end
   end

endmodule : xirq_prio
`default_nettype wire

// ---- core/xirq_top.sv ----
// Purpose: Extended interrupt flags, enables, priorities and baud doubler
// Assumes: Core special-function bus on mclk; bus sources pulse on mclk
// Notes: Outputs are registered, so requests lag their flags by one cycle
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Falling edge on pin five sets its sticky flag, flag register bit 7.
// - Rising edge on pin four sets its sticky flag, flag register bit 6.
// - Two-wire controller event sets flag bit 5; only software clears it.
// - USB interface event sets flag bit 4; only software clears it.
// - Writing one to a source flag raises its request like hardware would.
// - Reserved bits read fixed ones or zeros as laid out.
// - Wake-control bit 7 doubles the second serial port baud rate.
// - Wake-control bit 5 enables the resume request.
// - Wakeup pin rising or USB resume sets resume flag, bit 4.
// - Writing one to the resume flag raises a wakeup request if enabled.
// - Rising edge on pin six sets wake-control bit 3, sticky.
// - Writing one to pin six flag raises its request if enabled.
// - Enable bit 4 gates the pin six request.
// - Enable bit 3 gates the pin five request.
// - Enable bit 2 gates the pin four request.
// - Enable bit 1 gates the two-wire request.
// - Enable bit 0 gates the USB request.
// - Priority bits 4..2 put pins six, five, four in high group.
// - Priority bit 1 puts the two-wire source in the high group.
// - Priority bit 0 puts the USB source in the high group.
// - Global enable masks all these sources except resume.
// - Resume always wins at the top level, alone.
// - Equal-level ties go usb, two-wire, pin four, five, six.
module xirq_top
   import xirq_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Special-function register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // External pins
   input wire logic external_pin_four,
   input wire logic external_pin_five,
   input wire logic external_pin_six,
   input wire logic wakeup_pin,
   // On-chip event pulses
   input wire logic twowire_irq_pulse,
   input wire logic usb_irq_pulse,
   input wire logic usb_resume_pulse,
   // Standard unit control
   input wire logic global_irq_enable,
   // To the core sequencer
   output xirq_req_t irq_req,
   output xirq_req_t irq_high,
   output logic resume_req,
   output logic pend_valid,
   output logic [1:0] pend_level,
   output logic [3:0] pend_num,
   // To the second serial port
   output logic second_serial_baud_doubler
);

   function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] ofs);
      sfr_hit = (addr == ofs);
   endfunction : sfr_hit

   logic pin4_edge;
   logic pin5_edge;
   logic pin6_edge;
   logic wake_edge;

   xirq_edge #(.RISING(1'b1)) u_edge_pin4 (
      .mclk(mclk),
      .srst(srst),
      .pin(external_pin_four),
      .edge_pulse(pin4_edge)
   );

   xirq_edge #(.RISING(1'b0)) u_edge_pin5 (
      .mclk(mclk),
      .srst(srst),
      .pin(external_pin_five),
      .edge_pulse(pin5_edge)
   );

   xirq_edge #(.RISING(1'b1)) u_edge_pin6 (
      .mclk(mclk),
      .srst(srst),
      .pin(external_pin_six),
      .edge_pulse(pin6_edge)
   );

   xirq_edge #(.RISING(1'b1)) u_edge_wake (
      .mclk(mclk),
      .srst(srst),
      .pin(wakeup_pin),
      .edge_pulse(wake_edge)
   );

   // Register state
   logic pin5_edge_flag_q, pin5_edge_flag_d;
   logic pin4_edge_flag_q, pin4_edge_flag_d;
   logic twowire_request_flag_q, twowire_request_flag_d;
   logic usb_request_flag_q, usb_request_flag_d;
   logic resume_flag_q, resume_flag_d;
   logic pin6_edge_flag_q, pin6_edge_flag_d;
   logic resume_irq_enable_q, resume_irq_enable_d;
   logic dbl_q, dbl_d;
   logic [XIRQ_NSRC-1:0] en_q, en_d;
   logic [XIRQ_NSRC-1:0] pri_q, pri_d;
   logic [7:0] rdata_q, rdata_d;
   logic wr_flags, wr_wake, wr_en, wr_pri;

   always_comb begin
      wr_flags = sfr_wr && sfr_hit(sfr_addr, XIRQ_OFS_FLAGS);
      wr_wake = sfr_wr && sfr_hit(sfr_addr, XIRQ_OFS_WAKE);
      wr_en = sfr_wr && sfr_hit(sfr_addr, XIRQ_OFS_EN);
      wr_pri = sfr_wr && sfr_hit(sfr_addr, XIRQ_OFS_PRI);
      // Hardware set wins over a clearing write in the same cycle
      // software write sets flags
      pin5_edge_flag_d = pin5_edge | (wr_flags ? sfr_wdata[XIRQ_FLG_PIN5] : pin5_edge_flag_q);
      pin4_edge_flag_d = pin4_edge | (wr_flags ? sfr_wdata[XIRQ_FLG_PIN4] : pin4_edge_flag_q);
      twowire_request_flag_d = twowire_irq_pulse |
         (wr_flags ? sfr_wdata[XIRQ_FLG_TW] : twowire_request_flag_q);
      usb_request_flag_d = usb_irq_pulse |
         (wr_flags ? sfr_wdata[XIRQ_FLG_USB] : usb_request_flag_q);
      resume_flag_d = wake_edge | usb_resume_pulse |
         (wr_wake ? sfr_wdata[XIRQ_WAKE_RESUME_FLAG] : resume_flag_q);
      pin6_edge_flag_d = pin6_edge | (wr_wake ? sfr_wdata[XIRQ_WAKE_PIN6] : pin6_edge_flag_q);
      resume_irq_enable_d = wr_wake ? sfr_wdata[XIRQ_WAKE_ERES] : resume_irq_enable_q;
      dbl_d = wr_wake ? sfr_wdata[XIRQ_WAKE_DBL] : dbl_q;
      en_d = wr_en ? sfr_wdata[XIRQ_NSRC-1:0] : en_q;
      pri_d = wr_pri ? sfr_wdata[XIRQ_NSRC-1:0] : pri_q;
      rdata_d = rdata_q;
      if (sfr_rd) begin
         case (sfr_addr)
            XIRQ_OFS_FLAGS: rdata_d = XIRQ_FLAGS_ONES | {pin5_edge_flag_q, pin4_edge_flag_q,
               twowire_request_flag_q, usb_request_flag_q, 4'h0};
            XIRQ_OFS_WAKE: rdata_d = XIRQ_WAKE_ONES | {dbl_q, 1'b0, resume_irq_enable_q,
               resume_flag_q, pin6_edge_flag_q, 3'h0};
            XIRQ_OFS_EN: rdata_d = XIRQ_EN_ONES | {3'h0, en_q};
            XIRQ_OFS_PRI: rdata_d = XIRQ_PRI_ONES | {3'h0, pri_q};
            default: rdata_d = XIRQ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pin5_edge_flag_q <= XIRQ_RST_BIT;
         pin4_edge_flag_q <= XIRQ_RST_BIT;
         twowire_request_flag_q <= XIRQ_RST_BIT;
         usb_request_flag_q <= XIRQ_RST_BIT;
         resume_flag_q <= XIRQ_RST_BIT;
         pin6_edge_flag_q <= XIRQ_RST_BIT;
         resume_irq_enable_q <= XIRQ_RST_BIT;
         dbl_q <= XIRQ_RST_BIT;
         en_q <= XIRQ_RST_SRC;
         pri_q <= XIRQ_RST_SRC;
         rdata_q <= XIRQ_RST_BYTE;
      end else begin
         pin5_edge_flag_q <= pin5_edge_flag_d;
         pin4_edge_flag_q <= pin4_edge_flag_d;
         twowire_request_flag_q <= twowire_request_flag_d;
         usb_request_flag_q <= usb_request_flag_d;
         resume_flag_q <= resume_flag_d;
         pin6_edge_flag_q <= pin6_edge_flag_d;
         resume_irq_enable_q <= resume_irq_enable_d;
         dbl_q <= dbl_d;
         en_q <= en_d;
         pri_q <= pri_d;
         rdata_q <= rdata_d;
      end
   end

   // Request gating and arbitration
   xirq_req_t flags_v, req_d, req_q, high_q;
   logic resume_req_d, resume_req_q;
   logic pv_d, pv_q;
   logic [1:0] pl_d, pl_q;
   logic [3:0] pn_d, pn_q;

   always_comb begin
      flags_v = '{pin6: pin6_edge_flag_q, pin5: pin5_edge_flag_q, pin4: pin4_edge_flag_q,
                  twowire: twowire_request_flag_q, usb: usb_request_flag_q};
      req_d = flags_v & en_q & {XIRQ_NSRC{global_irq_enable}};
      resume_req_d = resume_flag_q & resume_irq_enable_q;
   end

   xirq_prio u_prio (
      .resume_req(resume_req_d),
      .req(req_d),
      .high(pri_q),
      .valid(pv_d),
      .level(pl_d),
      .num(pn_d)
   );

   always_ff @(posedge mclk) begin
      if (srst) begin
         req_q <= XIRQ_RST_SRC;
         high_q <= XIRQ_RST_SRC;
         resume_req_q <= XIRQ_RST_BIT;
         pv_q <= XIRQ_RST_BIT;
         pl_q <= XIRQ_LVL_LOW;
         pn_q <= XIRQ_NUM_RESUME;
      end else begin
         req_q <= req_d;
         high_q <= pri_q;
         resume_req_q <= resume_req_d;
         pv_q <= pv_d;
         pl_q <= pl_d;
         pn_q <= pn_d;
      end
   end

   assign sfr_rdata = rdata_q;
   assign irq_req = req_q;
   assign irq_high = high_q;
   assign resume_req = resume_req_q;
   assign pend_valid = pv_q;
   assign pend_level = pl_q;
   assign pend_num = pn_q;
   assign second_serial_baud_doubler = dbl_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   property p_pin5_set;
      pin5_edge |=> pin5_edge_flag_q;
   endproperty
   a_pin5_set: assert property (p_pin5_set) else $error("pin five flag not set");

   property p_pin4_set;
      pin4_edge |=> pin4_edge_flag_q;
   endproperty
   a_pin4_set: assert property (p_pin4_set) else $error("pin four flag not set");

   property p_tw_sticky;
      twowire_request_flag_q && !wr_flags |=> twowire_request_flag_q;
   endproperty
   a_tw_sticky: assert property (p_tw_sticky) else $error("two-wire flag dropped");

   property p_usb_set;
      usb_irq_pulse |=> usb_request_flag_q;
   endproperty
   a_usb_set: assert property (p_usb_set) else $error("usb flag not set");

   property p_sw_usb_req;
      (wr_flags && sfr_wdata[XIRQ_FLG_USB] && en_q[XIRQ_SRC_USB] && global_irq_enable)
         ##1 (global_irq_enable && !sfr_wr) |=> irq_req.usb;
   endproperty
   a_sw_usb_req: assert property (p_sw_usb_req) else $error("software usb set lost");

   property p_en_reserved;
      sfr_rd && sfr_addr == XIRQ_OFS_EN |=> sfr_rdata[7:5] == 3'h7;
   endproperty
   a_en_reserved: assert property (p_en_reserved) else $error("enable reserved bits wrong");

   property p_dbl;
      wr_wake |=> second_serial_baud_doubler == $past(sfr_wdata[XIRQ_WAKE_DBL]);
   endproperty
   a_dbl: assert property (p_dbl) else $error("baud doubler not written");

   property p_resume_mask;
      !resume_irq_enable_q |=> !resume_req;
   endproperty
   a_resume_mask: assert property (p_resume_mask) else $error("masked resume raised");

   property p_wake_set;
      wake_edge || usb_resume_pulse |=> resume_flag_q;
   endproperty
   a_wake_set: assert property (p_wake_set) else $error("resume flag not set");

   property p_pin6_set;
      pin6_edge |=> pin6_edge_flag_q;
   endproperty
   a_pin6_set: assert property (p_pin6_set) else $error("pin six flag not set");

   property p_global_mask;
      !global_irq_enable |=> irq_req == XIRQ_RST_SRC;
   endproperty
   a_global_mask: assert property (p_global_mask) else $error("request past global mask");

   property p_resume_top;
      resume_req |-> pend_valid && pend_level == XIRQ_LVL_TOP && pend_num == XIRQ_NUM_RESUME;
   endproperty
   a_resume_top: assert property (p_resume_top) else $error("resume not on top");

   property p_cov_usb;
      irq_req.usb && pend_num == XIRQ_NUM_BASE;
   endproperty
   c_cov_usb: cover property (p_cov_usb);

   property p_cov_resume;
      resume_req ##1 !resume_req;
   endproperty
   c_cov_resume: cover property (p_cov_resume);

   property p_cov_high;
      pend_valid && pend_level == XIRQ_LVL_HIGH && irq_req.usb;
   endproperty
   c_cov_high: cover property (p_cov_high);

endmodule : xirq_top
`default_nettype wire

// ---- verif/extended_irq_flag_enable_priority_tb_top.sv ----
// Purpose: Self-checking bench for the extended interrupt source block
// Assumes: Register bus strobes one cycle; read data lands after the taking edge
// Notes: Pins held 8 cycles per level to clear the three-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module extended_irq_flag_enable_priority_tb_top
   import xirq_pkg::*;
;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata;
   logic external_pin_four = 1'b0;
   logic external_pin_five = 1'b1;
   logic external_pin_six = 1'b0;
   logic wakeup_pin = 1'b0;
   logic twowire_irq_pulse = 1'b0;
   logic usb_irq_pulse = 1'b0;
   logic usb_resume_pulse = 1'b0;
   logic global_irq_enable = 1'b0;
   xirq_req_t irq_req;
   xirq_req_t irq_high;
   logic resume_req;
   logic pend_valid;
   logic [1:0] pend_level;
   logic [3:0] pend_num;
   logic second_serial_baud_doubler;
   logic [3:0] taken_num;
   logic [1:0] taken_level;
   logic top_misuse;
   int miscompares = 0;
   int n_checks = 0;

   always #4 mclk = ~mclk;

   xirq_top i_dut (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .external_pin_four(external_pin_four), .external_pin_five(external_pin_five),
      .external_pin_six(external_pin_six), .wakeup_pin(wakeup_pin),
      .twowire_irq_pulse(twowire_irq_pulse), .usb_irq_pulse(usb_irq_pulse),
      .usb_resume_pulse(usb_resume_pulse), .global_irq_enable(global_irq_enable),
      .irq_req(irq_req), .irq_high(irq_high), .resume_req(resume_req),
      .pend_valid(pend_valid), .pend_level(pend_level), .pend_num(pend_num),
      .second_serial_baud_doubler(second_serial_baud_doubler));

   xirq_core_model i_core (.mclk(mclk), .srst(srst), .pend_valid(pend_valid),
      .pend_level(pend_level), .pend_num(pend_num), .taken_num(taken_num),
      .taken_level(taken_level), .top_misuse(top_misuse));

   task automatic conclude;
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t %s got %h expected %h", $time, what, got, exp);
         miscompares++;
      end
   endtask : chk

   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : wait_n

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1;
      v = sfr_rdata;
   endtask : rd

   task automatic t_reserved;
      logic [7:0] v;
      logic [7:0] adr [4];
      logic [7:0] ones [4];
      adr = '{XIRQ_OFS_FLAGS, XIRQ_OFS_WAKE, XIRQ_OFS_EN, XIRQ_OFS_PRI};
      ones = '{8'hf8, 8'hf8, 8'hff, 8'hff};
      rd(8'h55, v);
      chk(v, 8'h00, "unmapped read");
      for (int i = 0; i < 4; i++) begin
         rd(adr[i], v);
         chk(v, i == 0 ? 8'h08 : (i == 1 ? 8'h40 : 8'he0), "reset value");
         wr(adr[i], 8'hff);
         rd(adr[i], v);
         chk(v, ones[i], "all ones written");
         wr(adr[i], 8'h00);
      end
   endtask : t_reserved

   task automatic t_pins;
      logic [7:0] v;
      @(posedge mclk) external_pin_five <= 1'b0;
      wait_n(8);
      rd(XIRQ_OFS_FLAGS, v);
      chk(v, 8'h88, "pin five fall");
      wr(XIRQ_OFS_FLAGS, 8'h00);
      @(posedge mclk) external_pin_five <= 1'b1;
      wait_n(8);
      rd(XIRQ_OFS_FLAGS, v);
      chk(v, 8'h08, "pin five rise ignored");
      @(posedge mclk) external_pin_four <= 1'b1;
      wait_n(8);
      rd(XIRQ_OFS_FLAGS, v);
      chk(v, 8'h48, "pin four rise");
      wr(XIRQ_OFS_FLAGS, 8'h00);
      @(posedge mclk) external_pin_four <= 1'b0;
      wait_n(8);
      rd(XIRQ_OFS_FLAGS, v);
      chk(v, 8'h08, "pin four fall ignored");
      @(posedge mclk) external_pin_six <= 1'b1;
      wait_n(8);
      rd(XIRQ_OFS_WAKE, v);
      chk(v, 8'h48, "pin six rise");
      wr(XIRQ_OFS_WAKE, 8'h00);
      @(posedge mclk) wakeup_pin <= 1'b1;
      wait_n(8);
      rd(XIRQ_OFS_WAKE, v);
      chk(v, 8'h50, "wakeup pin rise");
      wr(XIRQ_OFS_WAKE, 8'h00);
   endtask : t_pins

   task automatic t_events;
      logic [7:0] v;
      @(posedge mclk) usb_irq_pulse <= 1'b1;
      @(posedge mclk) usb_irq_pulse <= 1'b0;
      @(posedge mclk) twowire_irq_pulse <= 1'b1;
      @(posedge mclk) twowire_irq_pulse <= 1'b0;
      wait_n(6);
      rd(XIRQ_OFS_FLAGS, v);
      chk(v, 8'h38, "bus flags sticky");
      wr(XIRQ_OFS_FLAGS, 8'h20);
      rd(XIRQ_OFS_FLAGS, v);
      chk(v, 8'h28, "usb cleared alone");
      wr(XIRQ_OFS_FLAGS, 8'h00);
      @(posedge mclk) usb_resume_pulse <= 1'b1;
      @(posedge mclk) usb_resume_pulse <= 1'b0;
      rd(XIRQ_OFS_WAKE, v);
      chk(v, 8'h50, "usb resume");
      wr(XIRQ_OFS_WAKE, 8'h00);
   endtask : t_events

   task automatic t_gating;
      for (int k = 0; k < XIRQ_NSRC; k++) begin
         wr(XIRQ_OFS_EN, 8'h01 << k);
         // Global on before the flag write so the software set is seen live
         @(posedge mclk) global_irq_enable <= 1'b1;
         wr(XIRQ_OFS_FLAGS, 8'hf0);
         wr(XIRQ_OFS_WAKE, 8'h08);
         wait_n(3);
         chk({3'h0, irq_req}, 8'h01 << k, "one enable");
         chk({4'h0, pend_num}, 8'h08 + 8'(k), "single winner");
         @(posedge mclk) global_irq_enable <= 1'b0;
         wait_n(3);
         chk({3'h0, irq_req}, 8'h00, "global mask");
      end
      wr(XIRQ_OFS_FLAGS, 8'h00);
      wr(XIRQ_OFS_WAKE, 8'h00);
   endtask : t_gating

   task automatic t_priority;
      wr(XIRQ_OFS_EN, 8'h1f);
      wr(XIRQ_OFS_FLAGS, 8'hf0);
      wr(XIRQ_OFS_WAKE, 8'h08);
      @(posedge mclk) global_irq_enable <= 1'b1;
      for (int k = 0; k < XIRQ_NSRC; k++) begin
         wr(XIRQ_OFS_PRI, 8'h01 << k);
         wait_n(3);
         chk({3'h0, irq_high}, 8'h01 << k, "high group");
         chk({4'h0, pend_num}, 8'h08 + 8'(k), "high beats low");
         chk({6'h0, pend_level}, 8'h01, "high level");
      end
      wr(XIRQ_OFS_PRI, 8'h00);
      wait_n(3);
      chk({2'h0, pend_level, pend_num}, 8'h08, "low tie usb");
      wr(XIRQ_OFS_PRI, 8'h1e);
      wait_n(3);
      chk({2'h0, pend_level, pend_num}, 8'h19, "high tie twowire");
      wr(XIRQ_OFS_WAKE, 8'h38);
      wait_n(3);
      chk({5'h0, resume_req, pend_level}, 8'h06, "resume top");
      chk({4'h0, pend_num}, 8'h00, "resume number");
      chk({2'h0, taken_level, taken_num}, 8'h20, "sequencer took resume");
      chk({7'h0, top_misuse}, 8'h00, "top level exclusive");
      @(posedge mclk) global_irq_enable <= 1'b0;
      wait_n(3);
      chk({6'h0, resume_req, pend_valid}, 8'h03, "resume ignores global");
      wr(XIRQ_OFS_WAKE, 8'h18);
      wait_n(3);
      chk({6'h0, resume_req, pend_valid}, 8'h00, "resume masked");
      wr(XIRQ_OFS_WAKE, 8'h38);
      wait_n(6);
      chk({7'h0, resume_req}, 8'h01, "resume held");
      wr(XIRQ_OFS_WAKE, 8'h20);
      wait_n(3);
      chk({7'h0, resume_req}, 8'h00, "resume cleared");
      wr(XIRQ_OFS_WAKE, 8'h00);
      wr(XIRQ_OFS_FLAGS, 8'h00);
   endtask : t_priority

   task automatic t_doubler;
      logic [7:0] v;
      wr(XIRQ_OFS_WAKE, 8'h80);
      wait_n(2);
      chk({7'h0, second_serial_baud_doubler}, 8'h01, "doubler on");
      rd(XIRQ_OFS_WAKE, v);
      chk(v, 8'hc0, "doubler readback");
      wr(XIRQ_OFS_WAKE, 8'h00);
      wait_n(2);
      chk({7'h0, second_serial_baud_doubler}, 8'h00, "doubler off");
   endtask : t_doubler

   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      wait_n(6);
      t_reserved();
      t_pins();
      t_events();
      t_gating();
      t_priority();
      t_doubler();
      conclude();
   end

   // Run needs about three hundred cycles; ample margin
   initial begin
      #100000;
      miscompares++;
      conclude();
   end
endmodule : extended_irq_flag_enable_priority_tb_top
`default_nettype wire

// ---- verif/xirq_core_model.sv ----
// Purpose: Core sequencer stand-in that takes the winning request
// Assumes: Winner outputs are registered levels on mclk
// Notes: Latches the last winner; flags a top level given to anyone but resume
`timescale 1ns/1ps
`default_nettype none
module xirq_core_model
   import xirq_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Winner from the block
   input wire logic pend_valid,
   input wire logic [1:0] pend_level,
   input wire logic [3:0] pend_num,
   // What the sequencer took
   output logic [3:0] taken_num,
   output logic [1:0] taken_level,
   output logic top_misuse
);
   always_ff @(posedge mclk) begin
      if (srst) begin
         taken_num <= XIRQ_NUM_RESUME;
         taken_level <= XIRQ_LVL_LOW;
         top_misuse <= 1'b0;
      end else begin
         if (pend_valid) begin
            taken_num <= pend_num;
            taken_level <= pend_level;
         end
         if (pend_valid && pend_level == XIRQ_LVL_TOP && pend_num != XIRQ_NUM_RESUME) begin
            top_misuse <= 1'b1;
         end
      end
   end
endmodule : xirq_core_model
`default_nettype wire
